// [hw/tmr_map.svh]
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// register locations on the cpu i/o port (index of the 8-bit location)
`define TMR_ADDR_CNT_LO   4'h0
`define TMR_ADDR_CNT_HI   4'h1
`define TMR_ADDR_CAP_LO   4'h2
`define TMR_ADDR_CAP_HI   4'h3
`define TMR_ADDR_CMPA_LO  4'h4
`define TMR_ADDR_CMPA_HI  4'h5
`define TMR_ADDR_CTRL_A   4'h6
`define TMR_ADDR_CTRL_B   4'h7
`define TMR_ADDR_FLAGS    4'h8
`define TMR_ADDR_MASK     4'h9

// control_reg_a fields
`define TMR_A_WGM_LO      0
`define TMR_A_WGM_W       2
// control_reg_b fields
`define TMR_B_CS_LO       0
`define TMR_B_CS_W        3
`define TMR_B_WGM_HI_LO   3
`define TMR_B_WGM_HI_W    2
`define TMR_B_SRC_BIT     5
`define TMR_B_EDGE_BIT    6
// flag and mask bit positions
`define TMR_OVF_BIT       0
`define TMR_CAP_BIT       5

// reset values
`define TMR_RST_BYTE      8'h00
`define TMR_RST_WORD      16'h0000

// fixed top values and counter extremes
`define TMR_TOP_8BIT      16'h00ff
`define TMR_TOP_9BIT      16'h01ff
`define TMR_TOP_10BIT     16'h03ff
`define TMR_COUNT_MAX     16'hffff
`define TMR_COUNT_FLOOR   16'h0000

// clock select codes
`define TMR_CS_STOP       3'h0
`define TMR_CS_DIV1       3'h1
`define TMR_CS_DIV8       3'h2
`define TMR_CS_DIV64      3'h3
`define TMR_CS_DIV256     3'h4
`define TMR_CS_DIV1024    3'h5
`define TMR_CS_EXT_FALL   3'h6
`define TMR_CS_EXT_RISE   3'h7

// prescaler width needed for the slowest tap
`define TMR_PRESC_W       10

`endif

// [hw/tmr_pkg.sv]
package tmr_pkg;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} tmr_cpu_req_t;

	typedef enum logic [1:0] {
		TMR_OVF_AT_MAX   = 2'b00,
		TMR_OVF_AT_TOP   = 2'b01,
		TMR_OVF_AT_FLOOR = 2'b10
	} tmr_ovf_t;

	typedef enum logic [2:0] {
		TMR_TOP_MAX  = 3'b000,
		TMR_TOP_8    = 3'b001,
		TMR_TOP_9    = 3'b010,
		TMR_TOP_10   = 3'b011,
		TMR_TOP_CMPA = 3'b100,
		TMR_TOP_CAP  = 3'b101
	} tmr_top_sel_t;

	typedef struct packed {
		logic         dual;
		tmr_ovf_t     ovf;
		tmr_top_sel_t top_sel;
	} tmr_mode_t;

endpackage

// [hw/tmr_timer16.sv]
`timescale 1ns/1ps
`include "tmr_map.svh"
// Notes on behaviour
// - counter seen as two byte locations; upper location reaches the holding byte
// - reading counter low byte copies counter upper byte into holding byte
// - writing counter low byte loads all 16 bits using holding byte
// - each timer tick clears, increments or decrements counter per mode
// - three-bit clock select in control b; zero stops the counter
// - counter readable and writable whether or not ticks arrive
// - cpu counter write beats a coincident clear or count
// - four-bit waveform mode split across control a and b
// - top indication at sequence maximum, floor indication at zero
// - overflow flag set where the mode says, can request interrupt
// - capture fires on selected edge of pin or comparator output
// - capture copies full 16-bit counter into capture register
// - capture flag set in the same cycle as the copy
// - capture flag with enable set raises capture interrupt
// - capture flag cleared by interrupt service or writing one
// - capture low read copies capture high into holding byte
// - capture register writable only when it sets the top
// - holding byte keeps its value until an upper write or a counter or capture low read
// - one holding byte for all words; compare reads bypass it
// - top is 0xffff, 0x00ff, 0x01ff, 0x03ff, compare a or capture
module tmr_timer16
	import tmr_pkg::*;
#(
	parameter int PRESC_W = `TMR_PRESC_W
) (
	// clock and reset
	input  wire logic         mclk_in,
	input  wire logic         nrst_in,
	// cpu i/o port
	input  wire tmr_cpu_req_t cpu_req_in,
	output logic [7:0]        cpu_rdata_out,
	// interrupt service acknowledges
	input  wire logic         ovf_ack_in,
	input  wire logic         cap_ack_in,
	// pins
	input  wire logic         ext_clock_pin_in,
	input  wire logic         capture_input_pin_in,
	input  wire logic         comparator_output_in,
	// indications and interrupt requests
	output logic              count_top_out,
	output logic              count_floor_out,
	output logic              overflow_irq_out,
	output logic              capture_irq_out
);

	// the slowest tap reads the full prescaler, so a narrower one cannot serve it
	if (PRESC_W < `TMR_PRESC_W) begin : g_presc_check
		$error("prescaler too narrow for the slowest tap");
	end

	// holding byte and registers
	logic [7:0]         temp_reg;
	logic [15:0]        count_value_reg;
	logic [15:0]        capture_value_reg;
	logic [15:0]        compare_value_reg;
	logic [7:0]         control_reg_a;
	logic [7:0]         control_reg_b;
	logic               overflow_flag_reg;
	logic               capture_flag_reg;
	logic               ovf_irq_en_reg;
	logic               capture_irq_enable_reg;
	logic               count_down_reg;
	logic [PRESC_W-1:0] presc_reg;
	logic               ext_prev_reg;
	logic               cap_src_prev_reg;

	// decoded strobes
	logic               rd_cnt_lo;
	logic               rd_cap_lo;
	logic               wr_cnt_lo;
	logic               wr_cap_lo;
	logic               wr_cmpa_lo;
	logic               wr_hi;
	logic               wr_flags;
	logic [3:0]         waveform_mode_field;
	logic [2:0]         clock_select_field;
	tmr_mode_t          mode;
	logic [15:0]        top_value;
	logic               timer_tick;
	logic               cap_src;
	logic               cap_edge;
	logic               capture_trigger;
	logic               ovf_event;
	logic [15:0]        count_value_next;
	logic               count_down_next;

	function automatic logic is_wr(input tmr_cpu_req_t r, input logic [3:0] a);
		return r.wr && (r.addr == a);
	endfunction

	function automatic logic is_rd(input tmr_cpu_req_t r, input logic [3:0] a);
		return r.rd && (r.addr == a);
	endfunction

	// mode table: slope, overflow point and top source per waveform mode
	function automatic tmr_mode_t decode_mode(input logic [3:0] wgm);
		tmr_mode_t m;
		m = '{dual: 1'b0, ovf: TMR_OVF_AT_MAX, top_sel: TMR_TOP_MAX};
		case (wgm)
			4'h1: m = '{dual: 1'b1, ovf: TMR_OVF_AT_FLOOR, top_sel: TMR_TOP_8};
			4'h2: m = '{dual: 1'b1, ovf: TMR_OVF_AT_FLOOR, top_sel: TMR_TOP_9};
			4'h3: m = '{dual: 1'b1, ovf: TMR_OVF_AT_FLOOR, top_sel: TMR_TOP_10};
			4'h4: m = '{dual: 1'b0, ovf: TMR_OVF_AT_MAX, top_sel: TMR_TOP_CMPA};
			4'h5: m = '{dual: 1'b0, ovf: TMR_OVF_AT_TOP, top_sel: TMR_TOP_8};
			4'h6: m = '{dual: 1'b0, ovf: TMR_OVF_AT_TOP, top_sel: TMR_TOP_9};
			4'h7: m = '{dual: 1'b0, ovf: TMR_OVF_AT_TOP, top_sel: TMR_TOP_10};
			4'h8: m = '{dual: 1'b1, ovf: TMR_OVF_AT_FLOOR, top_sel: TMR_TOP_CAP};
			4'h9: m = '{dual: 1'b1, ovf: TMR_OVF_AT_FLOOR, top_sel: TMR_TOP_CMPA};
			4'ha: m = '{dual: 1'b1, ovf: TMR_OVF_AT_FLOOR, top_sel: TMR_TOP_CAP};
			4'hb: m = '{dual: 1'b1, ovf: TMR_OVF_AT_FLOOR, top_sel: TMR_TOP_CMPA};
			4'hc: m = '{dual: 1'b0, ovf: TMR_OVF_AT_MAX, top_sel: TMR_TOP_CAP};
			4'he: m = '{dual: 1'b0, ovf: TMR_OVF_AT_TOP, top_sel: TMR_TOP_CAP};
			4'hf: m = '{dual: 1'b0, ovf: TMR_OVF_AT_TOP, top_sel: TMR_TOP_CMPA};
			default: m = '{dual: 1'b0, ovf: TMR_OVF_AT_MAX, top_sel: TMR_TOP_MAX};
		endcase
		return m;
	endfunction

	// cpu strobes; one access per cycle, so these never collide
	assign rd_cnt_lo  = is_rd(cpu_req_in, `TMR_ADDR_CNT_LO);
	assign rd_cap_lo  = is_rd(cpu_req_in, `TMR_ADDR_CAP_LO);
	assign wr_cnt_lo  = is_wr(cpu_req_in, `TMR_ADDR_CNT_LO);
	assign wr_cap_lo  = is_wr(cpu_req_in, `TMR_ADDR_CAP_LO);
	assign wr_cmpa_lo = is_wr(cpu_req_in, `TMR_ADDR_CMPA_LO);
	assign wr_flags   = is_wr(cpu_req_in, `TMR_ADDR_FLAGS);
	assign wr_hi      = is_wr(cpu_req_in, `TMR_ADDR_CNT_HI) ||
		is_wr(cpu_req_in, `TMR_ADDR_CAP_HI) ||
		is_wr(cpu_req_in, `TMR_ADDR_CMPA_HI);

	assign waveform_mode_field = {
		control_reg_b[`TMR_B_WGM_HI_LO +: `TMR_B_WGM_HI_W],
		control_reg_a[`TMR_A_WGM_LO +: `TMR_A_WGM_W]
	};
	assign clock_select_field = control_reg_b[`TMR_B_CS_LO +: `TMR_B_CS_W];
	assign mode = decode_mode(waveform_mode_field);

	always_comb begin
		case (mode.top_sel)
			TMR_TOP_8:    top_value = `TMR_TOP_8BIT;
			TMR_TOP_9:    top_value = `TMR_TOP_9BIT;
			TMR_TOP_10:   top_value = `TMR_TOP_10BIT;
			TMR_TOP_CMPA: top_value = compare_value_reg;
			TMR_TOP_CAP:  top_value = capture_value_reg;
			default:      top_value = `TMR_COUNT_MAX;
		endcase
	end

	// prescaler free-runs only while a clock is selected
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			presc_reg <= '0;
		else if (clock_select_field == `TMR_CS_STOP)
			presc_reg <= '0;
		else
			presc_reg <= presc_reg + 1'b1;
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			ext_prev_reg <= 1'b0;
		else
			ext_prev_reg <= ext_clock_pin_in;
	end

	always_comb begin
		case (clock_select_field)
			`TMR_CS_DIV1:     timer_tick = 1'b1;
			`TMR_CS_DIV8:     timer_tick = &presc_reg[2:0];
			`TMR_CS_DIV64:    timer_tick = &presc_reg[5:0];
			`TMR_CS_DIV256:   timer_tick = &presc_reg[7:0];
			`TMR_CS_DIV1024:  timer_tick = &presc_reg[9:0];
			`TMR_CS_EXT_FALL: timer_tick = ext_prev_reg & ~ext_clock_pin_in;
			`TMR_CS_EXT_RISE: timer_tick = ~ext_prev_reg & ext_clock_pin_in;
			default:          timer_tick = 1'b0;
		endcase
	end

	// counter sequencing
	always_comb begin
		count_value_next = count_value_reg;
		count_down_next  = count_down_reg;
		if (wr_cnt_lo) begin
			count_value_next = {temp_reg, cpu_req_in.wdata};
		end else if (timer_tick) begin
			if (!mode.dual) begin
				count_down_next = 1'b0;
				if (count_value_reg == top_value)
					count_value_next = `TMR_COUNT_FLOOR;
				else
					count_value_next = count_value_reg + 16'h0001;
			end else if (count_down_reg) begin
				if (count_value_reg == `TMR_COUNT_FLOOR) begin
					count_down_next  = 1'b0;
					count_value_next = count_value_reg + 16'h0001;
				end else begin
					count_value_next = count_value_reg - 16'h0001;
				end
			end else begin
				// a top lowered below the count turns the slope at once
				if (count_value_reg >= top_value) begin
					count_down_next  = 1'b1;
					count_value_next = count_value_reg - 16'h0001;
				end else begin
					count_value_next = count_value_reg + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count_value_reg <= `TMR_RST_WORD;
			count_down_reg  <= 1'b0;
		end else begin
			count_value_reg <= count_value_next;
			count_down_reg  <= count_down_next;
		end
	end

	assign count_top_out   = (count_value_reg == top_value);
	assign count_floor_out = (count_value_reg == `TMR_COUNT_FLOOR);

	// a cpu counter low write cancels the tick, so it cannot raise overflow either
	always_comb begin
		ovf_event = 1'b0;
		if (timer_tick && !wr_cnt_lo) begin
			case (mode.ovf)
				TMR_OVF_AT_TOP:
					ovf_event = (count_value_reg == top_value);
				TMR_OVF_AT_FLOOR:
					ovf_event = count_down_reg && (count_value_reg == `TMR_COUNT_FLOOR);
				default:
					ovf_event = (count_value_reg == `TMR_COUNT_MAX);
			endcase
		end
	end

	// capture edge detection; disabled while capture register sets the top
	assign cap_src = control_reg_b[`TMR_B_SRC_BIT] ? comparator_output_in
		: capture_input_pin_in;

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			cap_src_prev_reg <= 1'b0;
		else
			cap_src_prev_reg <= cap_src;
	end

	assign cap_edge = control_reg_b[`TMR_B_EDGE_BIT] ? (~cap_src_prev_reg & cap_src)
		: (cap_src_prev_reg & ~cap_src);
	assign capture_trigger = cap_edge && (mode.top_sel != TMR_TOP_CAP);

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			capture_value_reg <= `TMR_RST_WORD;
		else if (capture_trigger)
			capture_value_reg <= count_value_reg;
		else if (wr_cap_lo && mode.top_sel == TMR_TOP_CAP)
			capture_value_reg <= {temp_reg, cpu_req_in.wdata};
	end

	// compare a is written directly; no double buffering here
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			compare_value_reg <= `TMR_RST_WORD;
		else if (wr_cmpa_lo)
			compare_value_reg <= {temp_reg, cpu_req_in.wdata};
	end

	// shared holding byte
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			temp_reg <= `TMR_RST_BYTE;
		else if (wr_hi)
			temp_reg <= cpu_req_in.wdata;
		else if (rd_cnt_lo)
			temp_reg <= count_value_reg[15:8];
		else if (rd_cap_lo)
			temp_reg <= capture_value_reg[15:8];
		// otherwise held, so one upper write serves several words
	end

	// control registers
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			control_reg_a <= `TMR_RST_BYTE;
			control_reg_b <= `TMR_RST_BYTE;
		end else if (is_wr(cpu_req_in, `TMR_ADDR_CTRL_A)) begin
			control_reg_a <= cpu_req_in.wdata;
		end else if (is_wr(cpu_req_in, `TMR_ADDR_CTRL_B)) begin
			control_reg_b <= cpu_req_in.wdata;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ovf_irq_en_reg         <= 1'b0;
			capture_irq_enable_reg <= 1'b0;
		end else if (is_wr(cpu_req_in, `TMR_ADDR_MASK)) begin
			ovf_irq_en_reg         <= cpu_req_in.wdata[`TMR_OVF_BIT];
			capture_irq_enable_reg <= cpu_req_in.wdata[`TMR_CAP_BIT];
		end
	end

	// flags: a new event wins over a clear in the same cycle
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			overflow_flag_reg <= 1'b0;
		else if (ovf_event)
			overflow_flag_reg <= 1'b1;
		else if (ovf_ack_in || (wr_flags && cpu_req_in.wdata[`TMR_OVF_BIT]))
			overflow_flag_reg <= 1'b0;
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			capture_flag_reg <= 1'b0;
		else if (capture_trigger)
			capture_flag_reg <= 1'b1;
		else if (cap_ack_in || (wr_flags && cpu_req_in.wdata[`TMR_CAP_BIT]))
			capture_flag_reg <= 1'b0;
	end

	assign overflow_irq_out = overflow_flag_reg && ovf_irq_en_reg;
	assign capture_irq_out  = capture_flag_reg && capture_irq_enable_reg;

	// read data, one cycle after the read strobe
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cpu_rdata_out <= `TMR_RST_BYTE;
		end else if (cpu_req_in.rd) begin
			case (cpu_req_in.addr)
				`TMR_ADDR_CNT_LO:  cpu_rdata_out <= count_value_reg[7:0];
				`TMR_ADDR_CNT_HI:  cpu_rdata_out <= temp_reg;
				`TMR_ADDR_CAP_LO:  cpu_rdata_out <= capture_value_reg[7:0];
				`TMR_ADDR_CAP_HI:  cpu_rdata_out <= temp_reg;
				`TMR_ADDR_CMPA_LO: cpu_rdata_out <= compare_value_reg[7:0];
				`TMR_ADDR_CMPA_HI: cpu_rdata_out <= compare_value_reg[15:8];
				`TMR_ADDR_CTRL_A:  cpu_rdata_out <= control_reg_a;
				`TMR_ADDR_CTRL_B:  cpu_rdata_out <= control_reg_b;
				`TMR_ADDR_FLAGS: begin
					cpu_rdata_out <= `TMR_RST_BYTE;
					cpu_rdata_out[`TMR_OVF_BIT] <= overflow_flag_reg;
					cpu_rdata_out[`TMR_CAP_BIT] <= capture_flag_reg;
				end
				`TMR_ADDR_MASK: begin
					cpu_rdata_out <= `TMR_RST_BYTE;
					cpu_rdata_out[`TMR_OVF_BIT] <= ovf_irq_en_reg;
					cpu_rdata_out[`TMR_CAP_BIT] <= capture_irq_enable_reg;
				end
				default: cpu_rdata_out <= `TMR_RST_BYTE;
			endcase
		end
	end

endmodule

// [verif/tmr_timer16_sva.sv]
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_timer16_chk
	import tmr_pkg::*;
#(
	parameter int PRESC_W = `TMR_PRESC_W
) (
	// clock and reset
	input wire logic         mclk_in,
	input wire logic         nrst_in,
	// cpu port
	input wire tmr_cpu_req_t cpu_req_in,
	input wire logic [7:0]   cpu_rdata_out,
	// acks and pins
	input wire logic         ovf_ack_in,
	input wire logic         cap_ack_in,
	input wire logic         ext_clock_pin_in,
	input wire logic         capture_input_pin_in,
	input wire logic         comparator_output_in,
	// indications
	input wire logic         count_top_out,
	input wire logic         count_floor_out,
	input wire logic         overflow_irq_out,
	input wire logic         capture_irq_out
);
	// shadows rebuilt from cpu traffic; the counter shadow is trusted only while stopped
	logic [7:0]  ca_reg, cb_reg, msk_reg, hold_reg;
	logic [15:0] cnt_reg;
	logic        hold_ok, cnt_ok, cs0, rd, wr;
	logic [3:0]  md, ad;
	assign rd = cpu_req_in.rd;
	assign wr = cpu_req_in.wr;
	assign ad = cpu_req_in.addr;
	assign cs0 = (cb_reg[2:0] == `TMR_CS_STOP);
	assign md = {cb_reg[4:3], ca_reg[1:0]};
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ca_reg <= 8'h00;
			cb_reg <= 8'h00;
			msk_reg <= 8'h00;
		end else if (wr) begin
			if (ad == `TMR_ADDR_CTRL_A) ca_reg <= cpu_req_in.wdata;
			if (ad == `TMR_ADDR_CTRL_B) cb_reg <= cpu_req_in.wdata;
			if (ad == `TMR_ADDR_MASK) msk_reg <= cpu_req_in.wdata;
		end
	end
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hold_reg <= 8'h00;
			hold_ok <= 1'b1;
		end else if (wr && (ad == 4'h1 || ad == 4'h3 || ad == 4'h5)) begin
			hold_reg <= cpu_req_in.wdata;
			hold_ok <= 1'b1;
		end else if (rd && ad == `TMR_ADDR_CNT_LO) begin
			hold_reg <= cnt_reg[15:8];
			hold_ok <= cnt_ok && cs0;
		end else if (rd && ad == `TMR_ADDR_CAP_LO) begin
			hold_ok <= 1'b0;
		end
	end
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_reg <= `TMR_RST_WORD;
			cnt_ok <= 1'b1;
		end else if (wr && ad == `TMR_ADDR_CNT_LO) begin
			cnt_reg <= {hold_reg, cpu_req_in.wdata};
			cnt_ok <= hold_ok && cs0;
		end else if (wr && ad == `TMR_ADDR_CTRL_B && cpu_req_in.wdata[2:0] != 3'h0) begin
			cnt_ok <= 1'b0;
		end
	end
	default clocking dcb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	a_cnt_read: assert property (rd && ad == `TMR_ADDR_CNT_LO && cnt_ok && cs0
		|=> cpu_rdata_out == cnt_reg[7:0]) else $error("counter low byte wrong");
	a_hold_read: assert property (rd && (ad == 4'h1 || ad == 4'h3)
		&& hold_ok |=> cpu_rdata_out == hold_reg) else $error("upper byte not from hold");
	a_floor_cnt: assert property (cnt_ok && cs0
		|-> count_floor_out == (cnt_reg == `TMR_COUNT_FLOOR)) else $error("floor wrong");
	a_rd_stands: assert property (!rd |=> $stable(cpu_rdata_out))
		else $error("read data moved");
	a_stop_still: assert property (cs0 && $past(cs0) && !$past(wr)
		|-> $stable(count_floor_out) && $stable(count_top_out)) else $error("stopped moved");
	a_cap_ack: assert property (cap_ack_in && !wr
		&& capture_input_pin_in == $past(capture_input_pin_in)
		&& comparator_output_in == $past(comparator_output_in)
		|=> !capture_irq_out) else $error("capture flag kept");
	a_ovf_ack: assert property (ovf_ack_in && cs0 && !wr |=> !overflow_irq_out)
		else $error("overflow flag kept");
	a_cap_edge: assert property ($rose(capture_input_pin_in)
		&& cb_reg[6:5] == 2'h2 && msk_reg[`TMR_CAP_BIT] && !wr && !(md[3] && !md[0])
		|=> capture_irq_out) else $error("capture missed");
	a_irq_mask: assert property ((capture_irq_out -> msk_reg[`TMR_CAP_BIT])
		&& (overflow_irq_out -> msk_reg[`TMR_OVF_BIT])) else $error("request while masked");
	c_cap: cover property (capture_irq_out);
	c_ovf: cover property (overflow_irq_out);
	c_top: cover property (count_top_out && cs0);
endmodule

bind tmr_timer16 tmr_timer16_chk #(.PRESC_W(PRESC_W)) u_chk (.mclk_in(mclk_in),
	.nrst_in(nrst_in), .cpu_req_in(cpu_req_in), .cpu_rdata_out(cpu_rdata_out),
	.ovf_ack_in(ovf_ack_in), .cap_ack_in(cap_ack_in), .ext_clock_pin_in(ext_clock_pin_in),
	.capture_input_pin_in(capture_input_pin_in), .comparator_output_in(comparator_output_in),
	.count_top_out(count_top_out), .count_floor_out(count_floor_out),
	.overflow_irq_out(overflow_irq_out), .capture_irq_out(capture_irq_out));

// [verif/tmr_cpu_model.sv]
`timescale 1ns/1ps
module tmr_cpu_model
	import tmr_pkg::*;
(
	// clock
	input  wire logic       mclk_in,
	// cpu port
	output tmr_cpu_req_t    req_out,
	input  wire logic [7:0] rdata_in
);
	initial req_out = '0;
	// one request per call, so sequences never interleave as an interrupt would
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		@(negedge mclk_in);
		req_out = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge mclk_in);
		// idle bus shows inverted values so stale data is never mistaken for real
		req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		@(negedge mclk_in);
		req_out = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h5a};
		@(negedge mclk_in);
		req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'ha5};
		d = rdata_in;
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] d);
		wr8(a + 4'h1, d[15:8]);
		wr8(a, d[7:0]);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] d);
		rd8(a, d[7:0]);
		rd8(a + 4'h1, d[15:8]);
	endtask
endmodule

// [verif/tmr_timer16_test.sv]
`timescale 1ns/1ps
module tmr_timer16_test
	import tmr_pkg::*;
;
	logic         mclk, nrst, ovf_ack, cap_ack, ext_pin, cap_pin, cmp_out;
	logic         top, floor, oirq, cirq;
	tmr_cpu_req_t req;
	logic [7:0]   rdata, b;
	logic [15:0]  v;
	int           n_fail = 0;
	int           num_checks = 0;
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	tmr_timer16 #(.PRESC_W(10)) DUT (.mclk_in(mclk), .nrst_in(nrst), .cpu_req_in(req),
		.cpu_rdata_out(rdata), .ovf_ack_in(ovf_ack), .cap_ack_in(cap_ack),
		.ext_clock_pin_in(ext_pin), .capture_input_pin_in(cap_pin),
		.comparator_output_in(cmp_out), .count_top_out(top), .count_floor_out(floor),
		.overflow_irq_out(oirq), .capture_irq_out(cirq));
	tmr_cpu_model cpu (.mclk_in(mclk), .req_out(req), .rdata_in(rdata));
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic t_reset();
		cpu.rd16(4'h0, v);
		chk("cnt", v, 16'h0000);
		cpu.rd16(4'h2, v);
		chk("cap", v, 16'h0000);
		cpu.rd8(4'h7, b);
		chk("ctl", 16'(b), 16'h0000);
		chk("flr", 16'(floor), 16'h0001);
	endtask
	task automatic t_atomic();
		cpu.wr16(4'h0, 16'h01ff);
		cpu.wr8(4'h1, 8'hab);
		cpu.rd16(4'h0, v);
		chk("cnt", v, 16'h01ff);
		cpu.wr8(4'h1, 8'h34);
		cpu.wr8(4'h0, 8'h56);
		cpu.wr8(4'h4, 8'h78);
		cpu.rd16(4'h0, v);
		chk("cnt", v, 16'h3456);
		cpu.wr16(4'h0, 16'h0102);
		cpu.rd8(4'h0, b);
		cpu.rd8(4'h5, b);
		chk("cmp", 16'(b), 16'h0034);
	endtask
	task automatic t_count();
		cpu.wr16(4'h0, 16'h00f0);
		cpu.wr8(4'h7, 8'h01);
		cpu.wr8(4'h1, 8'h00);
		cpu.wr8(4'h0, 8'h40);
		cpu.wr8(4'h7, 8'h00);
		cpu.rd16(4'h0, v);
		chk("run", v, 16'h0042);
		tick(20);
		cpu.rd16(4'h0, v);
		chk("stp", v, 16'h0042);
	endtask
	task automatic t_tops();
		logic [15:0] tp [4];
		tp = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff};
		for (int m = 0; m < 4; m++) begin
			cpu.wr8(4'h6, 8'(m));
			cpu.wr16(4'h0, tp[m]);
			chk("top", 16'(top), 16'h0001);
			cpu.wr16(4'h0, tp[m] - 16'h0001);
			chk("top", 16'(top), 16'h0000);
		end
		cpu.wr8(4'h6, 8'h00);
		cpu.wr8(4'h7, 8'h08);
		cpu.wr16(4'h4, 16'h0123);
		cpu.wr16(4'h0, 16'h0123);
		chk("top", 16'(top), 16'h0001);
	endtask
	task automatic t_capwr();
		cpu.wr8(4'h7, 8'h00);
		cpu.wr16(4'h2, 16'h1234);
		cpu.rd16(4'h2, v);
		chk("cap", v, 16'h0000);
		cpu.wr8(4'h7, 8'h18);
		cpu.wr16(4'h2, 16'h0345);
		cpu.rd16(4'h2, v);
		chk("cap", v, 16'h0345);
		cpu.wr16(4'h0, 16'h0345);
		chk("top", 16'(top), 16'h0001);
		cpu.wr8(4'h7, 8'h00);
	endtask
	task automatic t_ovf();
		cpu.wr8(4'h9, 8'h21);
		cpu.wr16(4'h0, 16'hfff8);
		cpu.wr8(4'h7, 8'h01);
		tick(30);
		cpu.wr8(4'h7, 8'h00);
		cpu.rd8(4'h8, b);
		chk("ovf", 16'(b[0]), 16'h0001);
		chk("oirq", 16'(oirq), 16'h0001);
		ovf_ack = 1'b1;
		tick(1);
		ovf_ack = 1'b0;
		chk("oirq", 16'(oirq), 16'h0000);
	endtask
	// dual slope on the external rising clock, then overflow at the floor on the fast tap
	task automatic t_modes();
		cpu.wr8(4'h6, 8'h01);
		cpu.wr16(4'h0, 16'h00fe);
		cpu.wr8(4'h7, 8'h07);
		repeat (4) begin
			ext_pin = 1'b1;
			tick(1);
			ext_pin = 1'b0;
			tick(1);
		end
		cpu.wr8(4'h7, 8'h00);
		cpu.rd16(4'h0, v);
		chk("ext", v, 16'h00fc);
		chk("oirq", 16'(oirq), 16'h0000);
		cpu.wr8(4'h7, 8'h01);
		tick(260);
		cpu.wr8(4'h7, 8'h00);
		chk("oirq", 16'(oirq), 16'h0001);
		cpu.wr8(4'h8, 8'h01);
		cpu.wr8(4'h6, 8'h00);
		chk("oirq", 16'(oirq), 16'h0000);
	endtask
	task automatic t_cap();
		cpu.wr16(4'h0, 16'h0abc);
		cpu.wr8(4'h7, 8'h40);
		cap_pin = 1'b1;
		tick(2);
		chk("cirq", 16'(cirq), 16'h0001);
		cpu.rd16(4'h2, v);
		chk("cap", v, 16'h0abc);
		cpu.wr8(4'h8, 8'h20);
		chk("cirq", 16'(cirq), 16'h0000);
		cpu.wr16(4'h0, 16'h0def);
		cap_pin = 1'b0;
		tick(2);
		chk("cirq", 16'(cirq), 16'h0000);
		cpu.wr8(4'h7, 8'h60);
		cmp_out = 1'b1;
		tick(2);
		chk("cirq", 16'(cirq), 16'h0001);
		cpu.rd16(4'h2, v);
		chk("cap", v, 16'h0def);
		cap_ack = 1'b1;
		tick(1);
		cap_ack = 1'b0;
		chk("cirq", 16'(cirq), 16'h0000);
	endtask
	initial begin
		nrst = 1'b0;
		ovf_ack = 1'b0;
		cap_ack = 1'b0;
		ext_pin = 1'b0;
		cap_pin = 1'b0;
		cmp_out = 1'b0;
		tick(16);
		nrst = 1'b1;
		t_reset();
		t_atomic();
		t_count();
		t_tops();
		t_capwr();
		t_ovf();
		t_modes();
		t_cap();
		close_out();
	end
	// the whole sequence needs well under 1000 cycles; 3000 leaves ample margin
	initial begin
		#300000;
		n_fail++;
		close_out();
	end
endmodule
